/* rtl/tx_queue_wrr_scheduler.sv */
// Weighted round-robin scheduler over sixteen transmit descriptor queues
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "wrr_defines.svh"

module tx_queue_wrr_scheduler (
  input wire logic mclk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [11:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // Message engine side
  input wire logic [15:0] queue_pending_i,
  input wire logic msg_done_i,
  input wire logic msg_fail_i,
  output logic send_req_o,
  output logic [3:0] queue_sel_o
);

  // ****************************************
  // State and slot lookup
  // ****************************************
  wrr_pkg::sched_regs_t st;
  wrr_pkg::sched_regs_t next_st;
  wrr_pkg::slot_entry_t cur;
  wrr_pkg::sched_regs_t rst_val;

  logic tbl_hit;
  logic stat_hit;
  logic [1:0] widx;
  logic attempt_end;
  logic [31:0] status_word;

  wrr_slot_pick i_wrr_slot_pick (
    .tbl_i(st.tbl),
    .slot_i(st.slot),
    .entry_o(cur)
  );

  // Byte address; the two low bits never select anything
  assign tbl_hit = ((address_i & `WRR_TBL_MASK) == `WRR_SLOTS_0_OFF);
  assign stat_hit = ((address_i & `WRR_WORD_MASK) == `WRR_STATUS_OFF);
  assign widx = address_i[`WRR_WORD_LSB +: `WRR_WIDX_W];
  assign attempt_end = (st.fsm == wrr_pkg::s_send) &&
                       (msg_done_i || msg_fail_i);

  // ****************************************
  // Status word, read-only
  // ****************************************
  // Software sees where the walk stands; writes to it are dropped
  always_comb
  begin
    status_word = `WRR_ZERO_WORD;
    status_word[`WRR_STAT_SLOT_LSB +: `WRR_FIELD_W] = st.slot;
    status_word[`WRR_STAT_USED_LSB +: `WRR_FIELD_W] = st.used;
    status_word[`WRR_STAT_QSEL_LSB +: `WRR_FIELD_W] = st.qsel;
    status_word[`WRR_STAT_BUSY_BIT] = (st.fsm == wrr_pkg::s_send);
  end

  // Reset table: slot n selects queue n once
  always_comb
  begin
    rst_val = '0;
    for (int w = 0; w < `WRR_NUM_WORDS; w++)
    begin
      for (int b = 0; b < `WRR_SLOTS_PER_WORD; b++)
      begin
        rst_val.tbl[w][b * `WRR_ENTRY_W + `WRR_SEL_LSB +: `WRR_FIELD_W] =
          4'(w * `WRR_SLOTS_PER_WORD + b);
        rst_val.tbl[w][b * `WRR_ENTRY_W + `WRR_CNT_LSB +: `WRR_FIELD_W] =
          `WRR_CNT_RESET;
      end
    end
    rst_val.fsm = wrr_pkg::s_eval;
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    next_st = st;

    // Every access is held off exactly one cycle, then answered
    next_st.ack = (read_i || write_i) && !st.ack;
    if (read_i && !st.ack)
    begin
      if (tbl_hit)
        next_st.rdata = st.tbl[widx];
      else if (stat_hit)
        next_st.rdata = status_word;
      else
        next_st.rdata = `WRR_ZERO_WORD;
    end
    if (write_i && st.ack && tbl_hit)
    begin
      // One byte lane holds one whole slot, so lanes map to slots
      for (int b = 0; b < `WRR_SLOTS_PER_WORD; b++)
      begin
        if (byteenable_i[b])
          next_st.tbl[widx][b * `WRR_ENTRY_W +: `WRR_ENTRY_W] =
            writedata_i[b * `WRR_ENTRY_W +: `WRR_ENTRY_W];
      end
    end

    case (st.fsm)
      wrr_pkg::s_eval:
      begin
        if (queue_pending_i[cur.sel])
        begin
          // Latch the slot so a table rewrite cannot move the head
          next_st.qsel = cur.sel;
          next_st.qcnt = cur.cnt;
          next_st.fsm = wrr_pkg::s_send;
        end
        else
        begin
          next_st.slot = 4'(st.slot + `WRR_ONE);
          next_st.used = `WRR_CNT_RESET;
        end
      end
      wrr_pkg::s_send:
      begin
        // Hold the same head request until it ends one way or other
        if (attempt_end)
        begin
          next_st.fsm = wrr_pkg::s_eval;
          if (st.used == st.qcnt)
          begin
            next_st.slot = 4'(st.slot + `WRR_ONE);
            next_st.used = `WRR_CNT_RESET;
          end
          else
          begin
            // Any attempt end, done or failed, spends one attempt of the slot's budget
            next_st.used = 4'(st.used + `WRR_ONE);
          end
        end
      end
      default:
      begin
        next_st.fsm = wrr_pkg::s_eval;
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      st <= rst_val;
    else
      st <= next_st;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign waitrequest_o = (read_i || write_i) && !st.ack;
  assign readdata_o = st.rdata;
  assign send_req_o = (st.fsm == wrr_pkg::s_send);
  assign queue_sel_o = st.qsel;

  // ****************************************
  // Assertions
  // ****************************************
  a_sel_from_table: assert property (@(posedge mclk_i) disable iff (rst_i)
    (st.fsm == wrr_pkg::s_eval) && queue_pending_i[cur.sel] |=>
      send_req_o &&
      queue_sel_o == $past(st.tbl[st.slot[3:2]][{st.slot[1:0], 3'h0}
        +: 4]))
    else $error("queue select does not match slot selector");

  a_count_bound: assert property (@(posedge mclk_i) disable iff (rst_i)
    send_req_o |-> st.used <= st.qcnt)
    else $error("attempts exceed slot count");

  a_advance_done: assert property (@(posedge mclk_i) disable iff (rst_i)
    attempt_end && st.used == st.qcnt |=>
      st.slot == 4'($past(st.slot) + 4'h1) && st.used == 4'h0 &&
      !send_req_o)
    else $error("slot did not advance after its count");

  a_table_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    write_i && !waitrequest_o && tbl_hit && byteenable_i == 4'hf |=>
      st.tbl[$past(widx)] == $past(writedata_i))
    else $error("slot word write lost");

  a_bus_answer: assert property (@(posedge mclk_i) disable iff (rst_i)
    (read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("bus request not answered in one cycle");

  a_wrap_slot: assert property (@(posedge mclk_i) disable iff (rst_i)
    st.slot == 4'hf && (st.fsm == wrr_pkg::s_eval) &&
      !queue_pending_i[cur.sel] |=> st.slot == 4'h0)
    else $error("slot 15 did not wrap to slot 0");

  a_retry_same: assert property (@(posedge mclk_i) disable iff (rst_i)
    st.fsm == wrr_pkg::s_send && msg_fail_i && st.used != st.qcnt |=>
      st.slot == $past(st.slot) &&
      st.used == 4'($past(st.used) + 4'h1))
    else $error("failed send did not retry the same slot");

  a_head_held: assert property (@(posedge mclk_i) disable iff (rst_i)
    send_req_o && !msg_done_i && !msg_fail_i |=>
      send_req_o && $stable(queue_sel_o))
    else $error("head request dropped before completion");

  a_skip_empty: assert property (@(posedge mclk_i) disable iff (rst_i)
    st.fsm == wrr_pkg::s_eval && !queue_pending_i[cur.sel] |=>
      !send_req_o && st.slot == 4'($past(st.slot) + 4'h1))
    else $error("empty queue slot was not skipped");

  // ****************************************
  // Bus assertions
  // ****************************************
  a_read_table: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    read_i && !waitrequest_o && tbl_hit |->
      readdata_o == st.tbl[widx])
    else $error("slot word read returned wrong data");

  a_read_unmapped: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    read_i && !waitrequest_o && !tbl_hit && !stat_hit |->
      readdata_o == `WRR_ZERO_WORD)
    else $error("unmapped read did not return zero");

  // Read data must not move while nobody is capturing a new word
  a_rdata_hold: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !(read_i && !st.ack) |=> $stable(readdata_o))
    else $error("read data changed without a read");

  a_status_ro: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    write_i && !waitrequest_o && stat_hit |=> $stable(st.tbl))
    else $error("status write altered the slot table");

  a_lane_write: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    write_i && !waitrequest_o && tbl_hit && byteenable_i == 4'h2 |=>
      st.tbl[$past(widx)][15:8] == $past(writedata_i[15:8]) &&
      st.tbl[$past(widx)][7:0] == $past(st.tbl[widx][7:0]))
    else $error("byte lane write hit the wrong slot");

  // ****************************************
  // Scheduler assertions
  // ****************************************
  a_qcnt_latch: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    st.fsm == wrr_pkg::s_eval && queue_pending_i[cur.sel] |=>
      st.qcnt == $past(cur.cnt))
    else $error("slot count not latched at send start");

  // Every attempt end costs one evaluation cycle before the next send
  a_end_reeval: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    attempt_end |=> !send_req_o)
    else $error("table not re-evaluated after an attempt");

  a_skip_used: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    st.fsm == wrr_pkg::s_eval && !queue_pending_i[cur.sel] |=>
      st.used == `WRR_CNT_RESET)
    else $error("skipped slot kept its attempt count");

  a_wrap_send: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    attempt_end && st.used == st.qcnt && st.slot == `WRR_LAST_SLOT |=>
      st.slot == `WRR_FIRST_SLOT)
    else $error("last slot did not wrap after its count");

endmodule
`default_nettype wire

/* rtl/wrr_defines.svh */
// Constants of the weighted round-robin transmit queue scheduler
`ifndef WRR_DEFINES_SVH
`define WRR_DEFINES_SVH

`define WRR_NUM_SLOTS 16
`define WRR_NUM_WORDS 4
`define WRR_SLOTS_PER_WORD 4
`define WRR_FIELD_W 4
`define WRR_ENTRY_W 8
`define WRR_SEL_LSB 0
`define WRR_CNT_LSB 4
`define WRR_CNT_RESET 4'h0
`define WRR_LAST_SLOT 4'hf
`define WRR_FIRST_SLOT 4'h0
`define WRR_ONE 4'h1

`define WRR_ADDR_W 12
`define WRR_SLOTS_0_OFF 12'h7e0
`define WRR_SLOTS_4_OFF 12'h7e4
`define WRR_SLOTS_8_OFF 12'h7e8
`define WRR_SLOTS_12_OFF 12'h7ec
`define WRR_STATUS_OFF 12'h7f0
`define WRR_TBL_BASE_HI 8'h7e
`define WRR_FULL_BE 4'hf
`define WRR_ZERO_WORD 32'h0000_0000
`define WRR_TBL_MASK 12'hff0
`define WRR_WORD_MASK 12'hffc
`define WRR_WORD_LSB 2
`define WRR_WIDX_W 2
`define WRR_STAT_SLOT_LSB 1
`define WRR_STAT_USED_LSB 5
`define WRR_STAT_QSEL_LSB 9
`define WRR_STAT_BUSY_BIT 13

`endif

/* rtl/wrr_pkg.sv */
// Types shared by the weighted round-robin scheduler files
package wrr_pkg;

  typedef enum logic [0:0] {s_eval, s_send} sched_state_t;

  // One schedule slot: queue selector and count-minus-one
  typedef struct packed {
    logic [3:0] cnt;
    logic [3:0] sel;
  } slot_entry_t;

  typedef struct packed {
    logic [3:0][31:0] tbl;
    logic ack;
    logic [31:0] rdata;
    sched_state_t fsm;
    logic [3:0] slot;
    logic [3:0] used;
    logic [3:0] qsel;
    logic [3:0] qcnt;
  } sched_regs_t;

endpackage

/* rtl/wrr_slot_pick.sv */
// Slot table unpacking and selection of the current slot entry
`timescale 1ns/100ps
`default_nettype none
`include "wrr_defines.svh"

module wrr_slot_pick (
  input wire logic [3:0][31:0] tbl_i,
  input wire logic [3:0] slot_i,
  output wrr_pkg::slot_entry_t entry_o
);

  wrr_pkg::slot_entry_t slots [`WRR_NUM_SLOTS];

  genvar g;
  generate
    for (g = 0; g < `WRR_NUM_SLOTS; g = g + 1)
    begin : g_slot
      // Byte lane g%4 of word g/4; selector low nibble, count high
      assign slots[g].sel = tbl_i[g / `WRR_SLOTS_PER_WORD]
        [(g % `WRR_SLOTS_PER_WORD) * `WRR_ENTRY_W + `WRR_SEL_LSB
         +: `WRR_FIELD_W];
      assign slots[g].cnt = tbl_i[g / `WRR_SLOTS_PER_WORD]
        [(g % `WRR_SLOTS_PER_WORD) * `WRR_ENTRY_W + `WRR_CNT_LSB
         +: `WRR_FIELD_W];
    end
  endgenerate

  assign entry_o = slots[slot_i];

endmodule
`default_nettype wire

/* tb/tx_queue_wrr_scheduler_tb.sv */
// Self-checking bench of the weighted round-robin scheduler
`timescale 1ns/100ps
`default_nettype none
module tx_queue_wrr_scheduler_tb;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] addr = 12'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] be = 4'h0;
  logic [31:0] rdata;
  logic waitreq;
  logic [15:0] pend = 16'h0000;
  logic done = 1'b0;
  logic fail = 1'b0;
  logic req;
  logic [3:0] qsel;
  logic [3:0] cnt;
  int err_count = 0;
  int n_checks = 0;
  int k;
  int j;
  int m;

  tx_queue_wrr_scheduler i_tx_queue_wrr_scheduler (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .address_i(addr),
    .read_i(rd),
    .write_i(wr),
    .writedata_i(wdata),
    .byteenable_i(be),
    .readdata_o(rdata),
    .waitrequest_o(waitreq),
    .queue_pending_i(pend),
    .msg_done_i(done),
    .msg_fail_i(fail),
    .send_req_o(req),
    .queue_sel_o(qsel)
  );

  initial forever #4 mclk_i = ~mclk_i;

  // ****************************
  // Bus and engine tasks
  // ****************************
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    err_count++;
    $display("[ERR] %0t wait ran out", $time);
    final_report();
  endtask

  // Waitrequest is read at the rising edge, before that edge updates it
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] b, input logic [31:0] exp);
    int i;
    @(posedge mclk_i);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    be <= b;
    for (i = 0; i < 50; i++)
    begin
      @(posedge mclk_i);
      if (waitreq === 1'b0)
        break;
    end
    if (i == 50)
      hang();
    if (!w)
      cmp32(rdata, exp);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic serve(input logic [3:0] q, input logic f);
    int i;
    for (i = 0; i < 100; i++)
    begin
      @(posedge mclk_i);
      if (req === 1'b1)
        break;
    end
    if (i == 100)
      hang();
    cmp32({28'h0000000, qsel}, {28'h0000000, q});
    done <= !f;
    fail <= f;
    @(posedge mclk_i);
    done <= 1'b0;
    fail <= 1'b0;
  endtask

  // ****************************
  // Test sequence
  // ****************************
  initial
  begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    pend <= 16'h0220;
    serve(4'h5, 1'b0);
    serve(4'h9, 1'b0);
    serve(4'h5, 1'b0);
    pend <= 16'h0000;
    for (k = 0; k < 4; k++)
      bus(1'b0, 12'(12'h7e0 + 4 * k), 32'h0, 4'hf,
        32'h03020100 + 32'h04040404 * k);
    bus(1'b0, 12'h100, 32'h0, 4'hf, 32'h0);
    for (k = 0; k < 2; k++)
    begin
      cnt = (k == 0) ? 4'h1 : 4'hf;
      bus(1'b1, 12'h7e4, {16'h0000, cnt, 4'h5, 8'h00}, 4'h2, 32'h0);
      bus(1'b0, 12'h7e4, 32'h0, 4'hf, {16'h0706, cnt, 4'h5, 8'h04});
      pend <= 16'h0020;
      serve(4'h5, 1'b1);
      pend <= 16'h0220;
      for (m = 0; m < cnt; m++)
        serve(4'h5, 1'b0);
      serve(4'h9, 1'b0);
      pend <= 16'h0000;
    end
    // Every selector code, with all slots aimed at the same queue
    for (k = 0; k < 16; k++)
    begin
      pend <= 16'h0000;
      for (j = 0; j < 4; j++)
        bus(1'b1, 12'(12'h7e0 + 4 * j), {4{4'h0, 4'(k)}}, 4'hf, 32'h0);
      pend <= 16'h0001 << k;
      serve(4'(k), 1'b0);
    end
    // Reset in mid-run restores the table; the held request shows in status
    rst_i <= 1'b1;
    pend <= 16'h0001;
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    bus(1'b0, 12'h7e0, 32'h0, 4'hf, 32'h03020100);
    bus(1'b0, 12'h7f0, 32'h0, 4'hf, 32'h0000_2000);
    bus(1'b1, 12'h7f0, 32'hffff_ffff, 4'hf, 32'h0);
    bus(1'b0, 12'h7f0, 32'h0, 4'hf, 32'h0000_2000);
    serve(4'h0, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
